//--- core/bbi_pkg.sv
// package: constants, encodings and carriers for the bounds branch init control
package bbi_pkg;
    localparam int CFG_W = 64;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_PRESERVE_BIT = 1;
    localparam int CFG_RSVD_LO = 2;
    localparam int CFG_RSVD_HI = 11;
    localparam int LA_BITS_DEF = 48;
    localparam logic [15:0] SMM_SAVE_OFFSET = 16'h7ed0;
    localparam logic [7:0] OP_PREFIX = 8'hf2;
    localparam logic [7:0] OP_CALL_REL = 8'he8;
    localparam logic [7:0] OP_GRP5 = 8'hff;
    localparam logic [2:0] GRP5_CALL_REG = 3'h2;
    localparam logic [2:0] GRP5_JMP_REG = 3'h4;
    localparam logic [7:0] OP_RET_IMM = 8'hc2;
    localparam logic [7:0] OP_RET = 8'hc3;
    localparam logic [7:0] OP_JMP_REL = 8'he9;
    localparam logic [7:0] OP_JMP_SHORT = 8'heb;
    localparam logic [3:0] OP_JCC_SHORT_HI = 4'h7;
    localparam logic [7:0] OP_ESCAPE = 8'h0f;
    localparam logic [3:0] OP_JCC_NEAR_HI = 4'h8;
    localparam logic [1:0] PL_USER = 2'h3;
    localparam logic [CFG_W-1:0] CFG_RESET = 64'h0;
    localparam logic [CFG_W-1:0] STATUS_RESET = 64'h0;

    // one retiring instruction as seen by the decoder
    typedef struct packed {
        logic valid;
        logic has_prefix;
        logic [7:0] op0;
        logic [7:0] op1;
        logic [2:0] modrm_reg;
    } bbi_insn_s;

    typedef enum logic [1:0] {
        BBI_RUN = 2'b00,
        BBI_SMM = 2'b01
    } bbi_mode_e;

    typedef struct packed {
        bbi_mode_e mode;
        logic [CFG_W-1:0] sup_cfg;
        logic [CFG_W-1:0] status;
        logic [CFG_W-1:0] smm_save;
        logic smm_save_we;
        logic [CFG_W-1:0] vm_control_structure_guest;
        logic vm_control_structure_guest_we;
        logic bnd_init;
        logic entry_fail;
    } bbi_state_s;
endpackage

//--- core/bbi_ctrl.sv
// bounds branch init control: branch init decision, range-check status, smm and vm handling
`timescale 1ns/1ps
`default_nettype none

module bbi_ctrl #(
    parameter int LA_BITS = bbi_pkg::LA_BITS_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire bbi_pkg::bbi_insn_s i_insn,
    input wire logic i_range_fault,
    input wire logic [1:0] i_current_privilege_level,
    input wire logic i_ext_state_save_on,
    input wire logic i_bound_regs_state_enable,
    input wire logic i_bound_csr_state_enable,
    input wire logic [bbi_pkg::CFG_W-1:0] i_user_bounds_config,
    input wire logic i_msr_write,
    input wire logic [bbi_pkg::CFG_W-1:0] i_msr_wdata,
    input wire logic i_sys_mgmt_interrupt,
    input wire logic i_resume_from_sys_mgmt,
    input wire logic [bbi_pkg::CFG_W-1:0] i_smm_restore_data,
    input wire logic i_vm_exit,
    input wire logic i_exit_clear_cfg,
    input wire logic i_vm_entry,
    input wire logic i_entry_load_cfg,
    input wire logic [bbi_pkg::CFG_W-1:0] i_vm_control_structure_guest_cfg,
    output logic [bbi_pkg::CFG_W-1:0] o_supervisor_bounds_config,
    output logic [bbi_pkg::CFG_W-1:0] o_bounds_status_reg,
    output logic o_bound_registers_init,
    output logic [bbi_pkg::CFG_W-1:0] o_smm_save_data,
    output logic [15:0] o_smm_save_offset,
    output logic o_smm_save_we,
    output logic [bbi_pkg::CFG_W-1:0] o_vm_control_structure_guest_data,
    output logic o_vm_control_structure_guest_we,
    output logic o_entry_fail_late,
    output logic o_in_sys_mgmt_mode
);
    bbi_pkg::bbi_state_s st;
    bbi_pkg::bbi_state_s next_st;
    logic is_call;
    logic is_ret;
    logic is_jmp;
    logic is_jcc;
    logic affected;
    logic [bbi_pkg::CFG_W-1:0] active_cfg;
    logic bounds_enabled;
    logic [bbi_pkg::CFG_W-1:0] restored;
    logic guest_bad;

    // opcode classes; eb and far forms fall through to no match
    always_comb begin
        is_call = (i_insn.op0 == bbi_pkg::OP_CALL_REL) ||
                  (i_insn.op0 == bbi_pkg::OP_GRP5 &&
                   i_insn.modrm_reg == bbi_pkg::GRP5_CALL_REG);
        is_ret = (i_insn.op0 == bbi_pkg::OP_RET_IMM) ||
                 (i_insn.op0 == bbi_pkg::OP_RET);
        is_jmp = (i_insn.op0 == bbi_pkg::OP_JMP_REL) ||
                 (i_insn.op0 == bbi_pkg::OP_GRP5 &&
                  i_insn.modrm_reg == bbi_pkg::GRP5_JMP_REG);
        is_jcc = (i_insn.op0[7:4] == bbi_pkg::OP_JCC_SHORT_HI) ||
                 (i_insn.op0 == bbi_pkg::OP_ESCAPE &&
                  i_insn.op1[7:4] == bbi_pkg::OP_JCC_NEAR_HI);
        affected = i_insn.valid && (is_call || is_ret || is_jmp || is_jcc);
    end

    // config that matches the privilege level
    always_comb begin
        active_cfg = (i_current_privilege_level == bbi_pkg::PL_USER) ?
                     i_user_bounds_config : st.sup_cfg;
        bounds_enabled = i_ext_state_save_on && i_bound_regs_state_enable &&
                         i_bound_csr_state_enable &&
                         active_cfg[bbi_pkg::CFG_EN_BIT];
    end

    // restore image: reserved bits forced low, base sign-extended from top la bit
    always_comb begin
        restored = i_smm_restore_data;
        restored[bbi_pkg::CFG_RSVD_HI:bbi_pkg::CFG_RSVD_LO] = '0;
        for (int b = LA_BITS; b < bbi_pkg::CFG_W; b++) begin
            restored[b] = i_smm_restore_data[LA_BITS-1];
        end
    end

    // guest value that a ring-0 model_reg_write would reject
    always_comb begin
        guest_bad = (i_vm_control_structure_guest_cfg[bbi_pkg::CFG_RSVD_HI:bbi_pkg::CFG_RSVD_LO] != '0);
        for (int b = LA_BITS; b < bbi_pkg::CFG_W; b++) begin
            if (i_vm_control_structure_guest_cfg[b] != i_vm_control_structure_guest_cfg[LA_BITS-1]) begin
                guest_bad = 1'b1;
            end
        end
    end

    // next state; mode events are mutually exclusive in the core, smi checked first
    always_comb begin
        next_st = st;
        next_st.smm_save_we = 1'b0;
        next_st.vm_control_structure_guest_we = 1'b0;
        next_st.entry_fail = 1'b0;
        // init pulse; the bound register file resets to unrestricted bounds
        next_st.bnd_init = affected && !i_insn.has_prefix &&
                           !active_cfg[bbi_pkg::CFG_PRESERVE_BIT];
        if (i_insn.valid && i_range_fault && bounds_enabled) begin
            next_st.status = '0;
        end
        if (i_msr_write) begin
            next_st.sup_cfg = i_msr_wdata;
        end
        unique case (st.mode)
            bbi_pkg::BBI_RUN: begin
                if (i_sys_mgmt_interrupt) begin
                    next_st.smm_save = st.sup_cfg;
                    next_st.smm_save_we = 1'b1;
                    next_st.sup_cfg = '0;
                    next_st.mode = bbi_pkg::BBI_SMM;
                end else if (i_vm_exit) begin
                    next_st.vm_control_structure_guest = st.sup_cfg;
                    next_st.vm_control_structure_guest_we = 1'b1;
                    // a software write in the same cycle loses to the exit
                    next_st.sup_cfg = st.sup_cfg;
                    if (i_exit_clear_cfg) begin
                        next_st.sup_cfg = '0;
                    end
                end else if (i_vm_entry && i_entry_load_cfg) begin
                    if (guest_bad) begin
                        next_st.entry_fail = 1'b1;
                        next_st.sup_cfg = st.sup_cfg; // failed entry keeps config
                    end else begin
                        next_st.sup_cfg = i_vm_control_structure_guest_cfg;
                    end
                end
            end
            bbi_pkg::BBI_SMM: begin
                if (i_resume_from_sys_mgmt) begin
                    next_st.sup_cfg = restored;
                    next_st.mode = bbi_pkg::BBI_RUN;
                end
            end
            default: begin
                next_st.mode = bbi_pkg::BBI_RUN;
            end
        endcase
    end

    // single state register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{mode: bbi_pkg::BBI_RUN, sup_cfg: bbi_pkg::CFG_RESET,
                    status: bbi_pkg::STATUS_RESET, smm_save: '0, smm_save_we: 1'b0,
                    vm_control_structure_guest: '0, vm_control_structure_guest_we: 1'b0, bnd_init: 1'b0,
                    entry_fail: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_supervisor_bounds_config = st.sup_cfg;
    assign o_bounds_status_reg = st.status;
    assign o_bound_registers_init = st.bnd_init;
    assign o_smm_save_data = st.smm_save;
    assign o_smm_save_offset = bbi_pkg::SMM_SAVE_OFFSET;
    assign o_smm_save_we = st.smm_save_we;
    assign o_vm_control_structure_guest_data = st.vm_control_structure_guest;
    assign o_vm_control_structure_guest_we = st.vm_control_structure_guest_we;
    assign o_entry_fail_late = st.entry_fail;
    assign o_in_sys_mgmt_mode = (st.mode == bbi_pkg::BBI_SMM);

    // checks on the branch decision; every answer is one cycle after the request
    // because the init pulse is registered, so branch checks use |=> or look back with $past

    // the prefix always wins over the preserve bit
    prefixed_keeps_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_insn.valid && i_insn.has_prefix) |=> !o_bound_registers_init)
        else $error("prefixed branch initialised bounds");

    // short relative jump is outside the affected set, prefix or not
    short_jmp_keeps_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_insn.op0 == bbi_pkg::OP_JMP_SHORT) |=> !o_bound_registers_init)
        else $error("short jump initialised bounds");

    // far forms and every other opcode fall outside the decode
    other_keeps_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !affected |=> !o_bound_registers_init)
        else $error("unaffected opcode initialised bounds");

    // legacy code path: no prefix and preserve clear means a full init
    unprefixed_init_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (affected && !i_insn.has_prefix && !active_cfg[bbi_pkg::CFG_PRESERVE_BIT])
        |=> o_bound_registers_init)
        else $error("unprefixed branch missed init");

    // preserve set keeps the bounds whatever the form
    preserve_keeps_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        active_cfg[bbi_pkg::CFG_PRESERVE_BIT] |=> !o_bound_registers_init)
        else $error("preserve set but bounds initialised");

    // the pulse may only follow a cycle whose active preserve bit was low
    preserve_bit_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_bound_registers_init |-> !$past(active_cfg[bbi_pkg::CFG_PRESERVE_BIT]))
        else $error("init despite preserve bit");

    // each pulse is backed by one retiring unprefixed affected branch
    init_source_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_bound_registers_init |-> $past(affected && !i_insn.has_prefix))
        else $error("init pulse without a branch");

    // relative call and both return opcodes, unprefixed, preserve clear
    call_ret_init_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_insn.valid && !i_insn.has_prefix && !active_cfg[bbi_pkg::CFG_PRESERVE_BIT] &&
         (i_insn.op0 == bbi_pkg::OP_CALL_REL || i_insn.op0 == bbi_pkg::OP_RET ||
          i_insn.op0 == bbi_pkg::OP_RET_IMM))
        |=> o_bound_registers_init)
        else $error("call or return missed init");

    // two-byte conditional jumps need the escape byte and the 8x second byte
    jcc_near_init_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_insn.valid && !i_insn.has_prefix && !active_cfg[bbi_pkg::CFG_PRESERVE_BIT] &&
         i_insn.op0 == bbi_pkg::OP_ESCAPE && i_insn.op1[7:4] == bbi_pkg::OP_JCC_NEAR_HI)
        |=> o_bound_registers_init)
        else $error("near conditional jump missed init");

    // checks on the range-check status path

    fault_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_insn.valid && i_range_fault && bounds_enabled) |=> (o_bounds_status_reg == '0))
        else $error("enabled fault left status nonzero");

    status_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !(i_insn.valid && i_range_fault && bounds_enabled) |=> $stable(o_bounds_status_reg))
        else $error("status changed without enabled fault");

    // without extended state saving the fault must not touch status
    enable_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_range_fault && !i_ext_state_save_on) |=> $stable(o_bounds_status_reg))
        else $error("status written while disabled");

    // checks on system-management entry and resume

    smi_save_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_in_sys_mgmt_mode && i_sys_mgmt_interrupt) |=>
        (o_smm_save_we && o_smm_save_data == $past(o_supervisor_bounds_config) &&
         o_supervisor_bounds_config == '0))
        else $error("smi save or clear wrong");

    // the save slot never moves
    save_offset_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_smm_save_we |-> (o_smm_save_offset == bbi_pkg::SMM_SAVE_OFFSET))
        else $error("save offset wrong");

    // the save strobe is a single-cycle pulse
    save_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_smm_save_we |=> !o_smm_save_we)
        else $error("save strobe held");

    // inside the handler resume is the only mode event that acts; vm events are dropped, msr writes still land
    smm_ignore_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_in_sys_mgmt_mode && !i_resume_from_sys_mgmt) |=>
        (o_in_sys_mgmt_mode && !o_vm_control_structure_guest_we && !o_entry_fail_late))
        else $error("event acted inside sys-mgmt mode");

    rsm_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_in_sys_mgmt_mode && i_resume_from_sys_mgmt) |=>
        (o_supervisor_bounds_config[bbi_pkg::CFG_RSVD_HI:bbi_pkg::CFG_RSVD_LO] == '0))
        else $error("resume left reserved bits set");

    // whatever the save area held, the reloaded base is canonical
    rsm_canon_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_in_sys_mgmt_mode && i_resume_from_sys_mgmt) |=>
        (o_supervisor_bounds_config[bbi_pkg::CFG_W-1:LA_BITS] ==
         {(bbi_pkg::CFG_W-LA_BITS){o_supervisor_bounds_config[LA_BITS-1]}}))
        else $error("resume left base non-canonical");

    // checks on virtual-machine exit and entry

    vm_exit_save_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_in_sys_mgmt_mode && !i_sys_mgmt_interrupt && i_vm_exit) |=>
        (o_vm_control_structure_guest_we && o_vm_control_structure_guest_data == $past(o_supervisor_bounds_config)))
        else $error("vm exit did not save config");

    exit_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_in_sys_mgmt_mode && !i_sys_mgmt_interrupt && i_vm_exit && i_exit_clear_cfg)
        |=> (o_supervisor_bounds_config == '0))
        else $error("exit did not clear config");

    // exit has priority, so a same-cycle entry is not looked at here
    entry_load_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_in_sys_mgmt_mode && !i_sys_mgmt_interrupt && !i_vm_exit && i_vm_entry &&
         i_entry_load_cfg && !guest_bad)
        |=> (o_supervisor_bounds_config == $past(i_vm_control_structure_guest_cfg)))
        else $error("entry did not load config");

    entry_bad_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!o_in_sys_mgmt_mode && !i_sys_mgmt_interrupt && !i_vm_exit && i_vm_entry &&
         i_entry_load_cfg && guest_bad)
        |=> o_entry_fail_late)
        else $error("bad guest value not refused");

    entry_fail_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_entry_fail_late |-> $stable(o_supervisor_bounds_config))
        else $error("failed entry changed config");

    // scenarios worth seeing at least once
    cov_init_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_bound_registers_init);
    cov_smm_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_smm_save_we ##[1:20] !o_in_sys_mgmt_mode);
    cov_exit_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_vm_control_structure_guest_we);
    cov_fail_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_entry_fail_late);
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the bounds branch init control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, ex, ac); end end

module tb_top;
    // narrow address width so canonicalisation really bites
    localparam int LA = 40;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    bbi_pkg::bbi_insn_s insn = '0;
    logic range_fault = 1'h0;
    logic [1:0] current_privilege_level = 2'h0;
    logic xs = 1'h0, rs = 1'h0, cs = 1'h0;
    logic [63:0] ucfg = '0, msr_d = '0, rdata = '0, gcfg = '0;
    logic msr_we = 1'h0, sys_mgmt_interrupt = 1'h0, resume_from_sys_mgmt = 1'h0, vexit = 1'h0;
    logic xclr = 1'h0, ventry = 1'h0, eload = 1'h0;
    logic [63:0] sup, status, sdata, gdata;
    logic [15:0] soff;
    logic binit, swe, gwe, efail, insmm, bad;
    logic [63:0] m_sup = '0;
    int failures = 0;
    int checks = 0;
    // branch families, far forms, short jump and a range-check slot last
    logic [7:0] ops [13] = '{8'he8, 8'hff, 8'hc2, 8'hc3, 8'he9, 8'h70, 8'h0f,
                             8'heb, 8'hea, 8'h9a, 8'hcb, 8'h90, 8'h62};

    initial forever #4 clk_sys = ~clk_sys;

    bbi_ctrl #(.LA_BITS(LA)) uut (
        .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_insn(insn),
        .i_range_fault(range_fault), .i_current_privilege_level(current_privilege_level),
        .i_ext_state_save_on(xs), .i_bound_regs_state_enable(rs),
        .i_bound_csr_state_enable(cs), .i_user_bounds_config(ucfg),
        .i_msr_write(msr_we), .i_msr_wdata(msr_d), .i_sys_mgmt_interrupt(sys_mgmt_interrupt),
        .i_resume_from_sys_mgmt(resume_from_sys_mgmt), .i_smm_restore_data(rdata), .i_vm_exit(vexit),
        .i_exit_clear_cfg(xclr), .i_vm_entry(ventry), .i_entry_load_cfg(eload),
        .i_vm_control_structure_guest_cfg(gcfg), .o_supervisor_bounds_config(sup),
        .o_bounds_status_reg(status), .o_bound_registers_init(binit),
        .o_smm_save_data(sdata), .o_smm_save_offset(soff), .o_smm_save_we(swe),
        .o_vm_control_structure_guest_data(gdata), .o_vm_control_structure_guest_we(gwe), .o_entry_fail_late(efail),
        .o_in_sys_mgmt_mode(insmm)
    );

    // reserved field cleared, upper bits copy the top implemented bit
    function automatic logic [63:0] canon(input logic [63:0] d);
        logic [63:0] r;
        r = d;
        r[11:2] = '0;
        for (int b = LA; b < 64; b++) r[b] = d[LA-1];
        return r;
    endfunction

    // one edge takes the request, outputs are read half a cycle later
    task automatic step();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [63:0] d);
        insn.valid = 1'h0;
        range_fault = 1'h0;
        msr_we = 1'h1;
        msr_d = d;
        step();
        msr_we = 1'h0;
        m_sup = d;
        `CHK("sup_write", d, sup)
    endtask

    // one retiring instruction; left valid so the next call is back to back
    task automatic br(input int k);
        logic [63:0] act;
        logic aff;
        insn.valid = 1'h1;
        insn.has_prefix = 1'($urandom);
        insn.op0 = ops[k] | ((k == 5) ? 8'($urandom % 16) : 8'h00);
        insn.op1 = 8'($urandom);
        insn.modrm_reg = 3'($urandom);
        range_fault = (k == 12) ? 1'($urandom) : 1'h0;
        current_privilege_level = 2'($urandom);
        {xs, rs, cs} = 3'($urandom);
        ucfg = {32'h0, $urandom};
        act = (current_privilege_level == bbi_pkg::PL_USER) ? ucfg : m_sup;
        aff = (insn.op0 inside {8'he8, 8'hc2, 8'hc3, 8'he9}) ||
              (insn.op0 == 8'hff && insn.modrm_reg inside {3'h2, 3'h4}) ||
              insn.op0[7:4] == 4'h7 || (insn.op0 == 8'h0f && insn.op1[7:4] == 4'h8);
        step();
        `CHK("bnd_init", aff & ~insn.has_prefix & ~act[1], binit)
        `CHK("status", 64'h0, status)
    endtask

    initial begin
        void'($urandom(12678));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'h0;
        `CHK("offset", 16'h7ed0, soff)
        // decode sweep over every opcode family, config rewritten now and then
        for (int i = 0; i < 300; i++) begin
            if (i % 25 == 0) wr({$urandom, $urandom});
            br($urandom % 13);
        end
        // sys-mgmt entry, a vm exit that must be ignored, then resume
        for (int i = 0; i < 8; i++) begin
            wr({$urandom, $urandom});
            sys_mgmt_interrupt = 1'h1;
            step();
            sys_mgmt_interrupt = 1'h0;
            `CHK("smm_we", 1'h1, swe)
            `CHK("smm_data", m_sup, sdata)
            `CHK("sup_smm", 64'h0, sup)
            `CHK("in_smm", 1'h1, insmm)
            vexit = 1'h1;
            step();
            vexit = 1'h0;
            `CHK("vm_we_smm", 1'h0, gwe)
            resume_from_sys_mgmt = 1'h1;
            rdata = {$urandom, $urandom};
            step();
            resume_from_sys_mgmt = 1'h0;
            m_sup = canon(rdata);
            `CHK("sup_rsm", m_sup, sup)
            `CHK("out_smm", 1'h0, insmm)
        end
        // vm exit with and without clear, entry with good and faulting guests
        for (int i = 0; i < 40; i++) begin
            wr({$urandom, $urandom});
            vexit = 1'h1;
            xclr = 1'($urandom);
            step();
            vexit = 1'h0;
            `CHK("vm_we", 1'h1, gwe)
            `CHK("vm_data", m_sup, gdata)
            if (xclr) m_sup = '0;
            `CHK("sup_exit", m_sup, sup)
            ventry = 1'h1;
            eload = 1'($urandom);
            gcfg = {$urandom, $urandom};
            if (i % 2) gcfg = canon(gcfg);
            step();
            ventry = 1'h0;
            bad = (gcfg != canon(gcfg));
            `CHK("entry_fail", eload & bad, efail)
            if (eload && !bad) m_sup = gcfg;
            `CHK("sup_entry", m_sup, sup)
        end
        give_verdict();
    end
endmodule
`default_nettype wire
